/* inc/lsg_map.svh */
// Address map, field positions, mode codes and reset values of the
// link sideband block. Included by the package and the design files.
`ifndef LSG_MAP_SVH
`define LSG_MAP_SVH

// Register addresses
`define LSG_ADDR_LINK 8'h0C
`define LSG_ADDR_PIN0 8'h0D
`define LSG_ADDR_PIN12 8'h0E
`define LSG_ADDR_PIN3 8'h0F
`define LSG_ADDR_LOC56 8'h10
`define LSG_ADDR_LOC78 8'h11
`define LSG_ADDR_AUDIO 8'h1A
`define LSG_ADDR_LEVELS 8'h1C
`define LSG_ADDR_LEVEL8 8'h1D
`define LSG_ADDR_IRQ_CTL 8'hC6
`define LSG_ADDR_IRQ_STAT 8'hC7

// Pin mode codes
`define LSG_MODE_OFF 4'h0
`define LSG_MODE_OUT_L 4'h1
`define LSG_MODE_OUT_H 4'h9
`define LSG_MODE_INPUT 4'h3
`define LSG_MODE_FWD 4'h3
`define LSG_MODE_BACK 4'h5

// Interrupt control and status, link status and audio bit positions
`define LSG_IRQ_GLOBAL_BIT 0
`define LSG_IRQ_LINK_BIT 1
`define LSG_IRQ_REMOTE_BIT 5
`define LSG_LINK_DETECT_BIT 0
`define LSG_AUDIO_SURROUND_BIT 0

// Reset values
`define LSG_RST_MODE 8'h00
`define LSG_RST_AUDIO 8'h01
`define LSG_RST_IRQ_CTL 8'h00
`define LSG_RST_RDATA 8'h00

// Forward frame width and pin counts
`define LSG_FWD_FRAME_BITS 35
`define LSG_LINK_PINS 4
`define LSG_ALL_PINS 8

`endif

/* inc/lsg_pkg.sv */
// Types and mode decoding shared by the sideband block files.
// Assumes lsg_map.svh is on the include path.
`include "lsg_map.svh"

package lsg_pkg;

  typedef logic [3:0] lsg_mode_type;
  typedef logic [7:0] lsg_byte_type;

  // True when the mode field claims the pin for general-purpose use
  function automatic logic lsg_mode_used(input lsg_mode_type mode);
    lsg_mode_used = (mode == `LSG_MODE_OUT_L) || (mode == `LSG_MODE_OUT_H) ||
                    (mode == `LSG_MODE_INPUT) || (mode == `LSG_MODE_BACK);
  endfunction

endpackage

/* rtl/lsg_pin_cell.sv */
// One general-purpose pin: synchroniser, local drive, forward sample
// and back-channel drive. Assumes frame strobes come from clk logic.
`timescale 1ns/1ps
`default_nettype none
`include "lsg_map.svh"

module lsg_pin_cell #(
  parameter bit REMOTE = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire lsg_pkg::lsg_mode_type mode,
  input wire logic pin_in,
  input wire logic fwd_strobe,
  input wire logic back_valid,
  input wire logic back_value,
  output logic pin_out,
  output logic pin_oe_n,
  output logic level,
  output logic fwd_value
);
  import lsg_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic fwd_value;
    logic back_value;
    logic drive;
    logic oe_n;
  } lsg_cell_state_type;

  lsg_cell_state_type st;
  lsg_cell_state_type next_st;

  // Next state of the pin
  always_comb begin
    next_st = st;
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;
    if (REMOTE && fwd_strobe && mode == `LSG_MODE_FWD) begin
      next_st.fwd_value = st.sync2; // RULE_22
    end
    if (REMOTE && back_valid) begin
      next_st.back_value = back_value; // RULE_22
    end
    case (mode)
      `LSG_MODE_OUT_L: begin
        next_st.drive = 1'b0; // RULE_03
        next_st.oe_n = 1'b0;
      end
      `LSG_MODE_OUT_H: begin
        next_st.drive = 1'b1; // RULE_03
        next_st.oe_n = 1'b0;
      end
      `LSG_MODE_BACK: begin
        next_st.drive = REMOTE ? st.back_value : 1'b0; // RULE_01
        next_st.oe_n = !REMOTE;
      end
      default: begin
        next_st.drive = 1'b0;
        next_st.oe_n = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs from flip-flops
  assign pin_out = st.drive;
  assign pin_oe_n = st.oe_n;
  assign level = (mode == `LSG_MODE_INPUT) ? st.sync2 : 1'b0; // RULE_04
  assign fwd_value = st.fwd_value;

  a_out_high: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
    (mode == `LSG_MODE_OUT_H) |=> (pin_out && !pin_oe_n))
    else $error("pin not driven high in high-output mode");

  a_out_low: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
    (mode == `LSG_MODE_OUT_L) |=> (!pin_out && !pin_oe_n))
    else $error("pin not driven low in low-output mode");

  a_fwd_sample: assert property (@(posedge clk) disable iff (!reset_n) // RULE_22
    (REMOTE && fwd_strobe && mode == `LSG_MODE_FWD) |=> (fwd_value == $past(st.sync2)))
    else $error("forward value not sampled on frame strobe");

  a_back_drive: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
    (REMOTE && back_valid && mode == `LSG_MODE_BACK && $stable(mode))
      ##1 (mode == `LSG_MODE_BACK && !back_valid) |=> (pin_out == $past(back_value, 2) && !pin_oe_n))
    else $error("back-channel value not driven on pin");

endmodule
`default_nettype wire

/* rtl/lsg_top.sv */
// Sideband control of the serializer: pin modes, pin levels, link
// status, local and remote interrupt, register reset on power-down.
// Assumes the local and control-channel register ports and the
// back-channel frame decoder all run on clk.
//
// Function
// RULE_01: Link pins carry forward or back state
// RULE_02: Codes 3 forward, 5 back, per-pin fields
// RULE_03: Codes 1 low, 9 high, 3 input
// RULE_04: Input levels readable in level registers
// RULE_05: Pins 5-8 controlled only through registers
// RULE_06: Pin mode overrides shared audio input
// RULE_07: Local pins never cross link, both ports
// RULE_08: Active-low interrupt for local and remote
// RULE_09: Host sets enable bits 5 and 0
// RULE_10: Remote low input drives interrupt low
// RULE_11: Status read clears pending, releases interrupt
// RULE_12: Host reads status, clears remote source
// RULE_13: New remote interrupt only on falling edge
// RULE_14: Mirror output follows remote level continuously
// RULE_15: Mirror held high without link
// RULE_16: Any cable fault reads link bit 0
// RULE_17: Single fault indication, no fault type
// RULE_18: Power-down resets every control register
// RULE_19: Power-down held low at least 3 ms
// RULE_20: Back frames carry bus, CRC, four pins
// RULE_21: Forward frame carries 35 bits per clock
// RULE_22: Forward samples pin, back drives last value
`timescale 1ns/1ps
`default_nettype none
`include "lsg_map.svh"

module lsg_top #(
  parameter int N_PINS = `LSG_ALL_PINS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic power_down_n,
  input wire logic link_detect,
  input wire logic loc_req,
  input wire logic loc_we,
  input wire lsg_pkg::lsg_byte_type loc_addr,
  input wire lsg_pkg::lsg_byte_type loc_wdata,
  output lsg_pkg::lsg_byte_type loc_rdata,
  output logic loc_rvalid,
  input wire logic rem_req,
  input wire logic rem_we,
  input wire lsg_pkg::lsg_byte_type rem_addr,
  input wire lsg_pkg::lsg_byte_type rem_wdata,
  output logic rem_ready,
  output lsg_pkg::lsg_byte_type rem_rdata,
  output logic rem_rvalid,
  input wire logic back_frame_valid,
  input wire logic back_frame_crc_ok,
  input wire logic [3:0] back_frame_gpio,
  input wire logic back_frame_irq_n,
  input wire logic fwd_frame_strobe,
  output logic [3:0] fwd_frame_gpio,
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe_n,
  output logic [3:0] i2s_in_enable,
  output logic audio_surround_en,
  output logic irq_out_n,
  output logic remote_irq_mirror
);
  import lsg_pkg::*;

  // Refuse pin counts the map cannot serve
  if (N_PINS != `LSG_ALL_PINS) begin : g_bad_pins
    $error("lsg_top supports exactly eight pins");
  end

  typedef struct packed {
    logic pd1;
    logic pd2;
    logic lk1;
    logic lk2;
    logic link_prev;
    logic [4:0][7:0] mode_reg;
    lsg_byte_type audio;
    lsg_byte_type irq_ctl;
    logic rem_pend;
    logic link_pend;
    logic rem_level;
    lsg_byte_type rdata;
    logic loc_rvalid;
    logic rem_rvalid;
  } lsg_top_state_type;

  lsg_top_state_type st;
  lsg_top_state_type next_st;

  logic frame_ok;
  logic acc;
  logic acc_we;
  lsg_byte_type acc_addr;
  lsg_byte_type acc_wdata;
  logic rem_fall;
  logic link_fall;
  logic [7:0] lvl;
  logic [3:0] fwd_bits;
  lsg_mode_type [7:0] modes;

  // Frames pass only with a good check word
  assign frame_ok = back_frame_valid && back_frame_crc_ok && st.lk2; // RULE_20

  // Local port wins; control-channel port waits for a free cycle
  assign rem_ready = !loc_req; // RULE_07
  assign acc = loc_req || rem_req;
  assign acc_we = loc_req ? loc_we : rem_we;
  assign acc_addr = loc_req ? loc_addr : rem_addr;
  assign acc_wdata = loc_req ? loc_wdata : rem_wdata;

  // Per-pin mode fields
  assign modes[0] = st.mode_reg[0][3:0]; // RULE_02
  assign modes[1] = st.mode_reg[1][3:0];
  assign modes[2] = st.mode_reg[1][7:4];
  assign modes[3] = st.mode_reg[2][3:0];
  assign modes[4] = st.mode_reg[3][3:0]; // RULE_05
  assign modes[5] = st.mode_reg[3][7:4];
  assign modes[6] = st.mode_reg[4][3:0];
  assign modes[7] = st.mode_reg[4][7:4];

  // Pin cells: four link pins, four register-only pins
  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    logic fwd_unused;
    lsg_pin_cell #(
      .REMOTE(i < `LSG_LINK_PINS)
    ) u_cell (
      .clk(clk),
      .reset_n(reset_n),
      .mode(modes[i]),
      .pin_in(gpio_in[i]),
      .fwd_strobe(fwd_frame_strobe),
      .back_valid(frame_ok),
      .back_value(i < `LSG_LINK_PINS ? back_frame_gpio[i % `LSG_LINK_PINS] : 1'b0),
      .pin_out(gpio_out[i]),
      .pin_oe_n(gpio_oe_n[i]),
      .level(lvl[i]),
      .fwd_value(fwd_unused)
    );
    if (i < `LSG_LINK_PINS) begin : g_fwd
      assign fwd_bits[i] = fwd_unused; // RULE_21
    end
  end

  // Only link pins fill the pin slots of the 35-bit forward frame
  assign fwd_frame_gpio = fwd_bits; // RULE_07

  // General-purpose mode takes the shared audio input away
  for (genvar k = 0; k < 4; k++) begin : g_audio
    assign i2s_in_enable[k] = !lsg_mode_used(modes[k + `LSG_LINK_PINS]); // RULE_06
  end

  // Register read decode
  function automatic lsg_byte_type reg_read(input lsg_byte_type addr, input lsg_top_state_type s,
                                            input logic [7:0] lv);
    case (addr)
      `LSG_ADDR_LINK: reg_read = {7'h00, s.lk2}; // RULE_16
      `LSG_ADDR_PIN0: reg_read = s.mode_reg[0];
      `LSG_ADDR_PIN12: reg_read = s.mode_reg[1];
      `LSG_ADDR_PIN3: reg_read = s.mode_reg[2];
      `LSG_ADDR_LOC56: reg_read = s.mode_reg[3];
      `LSG_ADDR_LOC78: reg_read = s.mode_reg[4];
      `LSG_ADDR_AUDIO: reg_read = s.audio;
      `LSG_ADDR_LEVELS: reg_read = {lv[6], lv[5], lv[4], 1'b0, lv[3:0]}; // RULE_04
      `LSG_ADDR_LEVEL8: reg_read = {7'h00, lv[7]};
      `LSG_ADDR_IRQ_CTL: reg_read = s.irq_ctl;
      `LSG_ADDR_IRQ_STAT: reg_read = {2'h0, s.rem_pend, 3'h0, s.link_pend, s.rem_pend | s.link_pend};
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Next state: sync, registers, interrupt flags, power-down
  always_comb begin
    next_st = st;
    next_st.pd1 = power_down_n;
    next_st.pd2 = st.pd1;
    next_st.lk1 = link_detect;
    next_st.lk2 = st.lk1;
    next_st.link_prev = st.lk2;
    next_st.loc_rvalid = 1'b0;
    next_st.rem_rvalid = 1'b0;
    // Remote level tracks good frames, idles high without link
    if (!st.lk2) begin
      next_st.rem_level = 1'b1; // RULE_15
    end else if (frame_ok) begin
      next_st.rem_level = back_frame_irq_n; // RULE_14
    end
    rem_fall = st.rem_level && !next_st.rem_level; // RULE_13
    link_fall = st.link_prev && !st.lk2; // RULE_17
    if (acc && acc_we) begin
      case (acc_addr)
        `LSG_ADDR_PIN0: next_st.mode_reg[0] = acc_wdata;
        `LSG_ADDR_PIN12: next_st.mode_reg[1] = acc_wdata;
        `LSG_ADDR_PIN3: next_st.mode_reg[2] = acc_wdata;
        `LSG_ADDR_LOC56: next_st.mode_reg[3] = acc_wdata; // RULE_07
        `LSG_ADDR_LOC78: next_st.mode_reg[4] = acc_wdata;
        `LSG_ADDR_AUDIO: next_st.audio = acc_wdata;
        `LSG_ADDR_IRQ_CTL: next_st.irq_ctl = acc_wdata;
        default: next_st.rdata = st.rdata;
      endcase
    end else if (acc) begin
      next_st.rdata = reg_read(acc_addr, st, lvl);
      next_st.loc_rvalid = loc_req;
      next_st.rem_rvalid = !loc_req;
      if (acc_addr == `LSG_ADDR_IRQ_STAT) begin
        next_st.rem_pend = 1'b0; // RULE_11
        next_st.link_pend = 1'b0;
      end
    end
    // Set wins over the clearing read
    if (rem_fall && st.irq_ctl[`LSG_IRQ_REMOTE_BIT]) begin
      next_st.rem_pend = 1'b1; // RULE_13
    end
    if (link_fall && st.irq_ctl[`LSG_IRQ_LINK_BIT]) begin
      next_st.link_pend = 1'b1; // RULE_08
    end
    // Power-down returns every control register to default
    if (!st.pd2) begin
      next_st.mode_reg = {5{`LSG_RST_MODE}}; // RULE_18
      next_st.audio = `LSG_RST_AUDIO;
      next_st.irq_ctl = `LSG_RST_IRQ_CTL;
      next_st.rem_pend = 1'b0;
      next_st.link_pend = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.mode_reg <= {5{`LSG_RST_MODE}};
      st.audio <= `LSG_RST_AUDIO;
      st.irq_ctl <= `LSG_RST_IRQ_CTL;
      st.rdata <= `LSG_RST_RDATA;
      st.rem_level <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign loc_rdata = st.rdata;
  assign rem_rdata = st.rdata;
  assign loc_rvalid = st.loc_rvalid;
  assign rem_rvalid = st.rem_rvalid;
  assign audio_surround_en = st.audio[`LSG_AUDIO_SURROUND_BIT];
  assign irq_out_n = !(st.irq_ctl[`LSG_IRQ_GLOBAL_BIT] && (st.rem_pend || st.link_pend)); // RULE_10
  assign remote_irq_mirror = st.lk2 ? st.rem_level : 1'b1; // RULE_15

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_irq_drive_low: assert property ( // RULE_10
    (st.irq_ctl[`LSG_IRQ_GLOBAL_BIT] && st.irq_ctl[`LSG_IRQ_REMOTE_BIT] && st.pd2 && rem_fall)
      |=> !irq_out_n)
    else $error("remote fall did not pull interrupt low");

  a_read_clears: assert property ( // RULE_11
    (acc && !acc_we && acc_addr == `LSG_ADDR_IRQ_STAT && !rem_fall && !link_fall)
      |=> (irq_out_n && !st.rem_pend))
    else $error("status read did not release interrupt");

  a_edge_only: assert property ( // RULE_13
    $rose(st.rem_pend) |-> $fell(st.rem_level))
    else $error("remote pending set without falling edge");

  a_mirror_nolink: assert property ( // RULE_15
    !st.lk2 |-> remote_irq_mirror)
    else $error("mirror low while unlinked");

  a_mirror_follow: assert property ( // RULE_14
    frame_ok ##1 st.lk2 |-> remote_irq_mirror == $past(back_frame_irq_n))
    else $error("mirror does not follow remote level");

  a_link_status: assert property ( // RULE_16
    (acc && !acc_we && acc_addr == `LSG_ADDR_LINK) |=> (st.rdata[`LSG_LINK_DETECT_BIT] == $past(st.lk2)))
    else $error("link status read wrong");

  a_pd_defaults: assert property ( // RULE_18
    !st.pd2 |=> (st.irq_ctl == `LSG_RST_IRQ_CTL && st.audio == `LSG_RST_AUDIO && irq_out_n))
    else $error("power-down did not restore defaults");

  a_audio_override: assert property ( // RULE_06
    (modes[4] == `LSG_MODE_OUT_H) |-> !i2s_in_enable[0])
    else $error("audio input still enabled in pin mode");

endmodule
`default_nettype wire

/* tb/lsg_deser_model.sv */
// Companion deserializer model: one back frame every eight clocks.
// Assumes the bench sets pin states, interrupt level and CRC fault.
`timescale 1ns/1ps
`default_nettype none
module lsg_deser_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] gpio_tx,
  input wire logic irq_tx_n,
  input wire logic crc_bad,
  output logic back_frame_valid,
  output logic back_frame_crc_ok,
  output logic [3:0] back_frame_gpio,
  output logic back_frame_irq_n
);
  logic [2:0] gap;
  // Frame pulse with payload; lines toggle between frames so stale data never looks valid
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap <= 3'h0;
      back_frame_valid <= 1'b0;
      back_frame_crc_ok <= 1'b0;
      back_frame_gpio <= 4'h0;
      back_frame_irq_n <= 1'b1;
    end else begin
      gap <= gap + 3'h1;
      back_frame_valid <= (gap == 3'h7);
      if (gap == 3'h7) begin
        back_frame_crc_ok <= !crc_bad;
        back_frame_gpio <= gpio_tx;
        back_frame_irq_n <= irq_tx_n;
      end else begin
        back_frame_crc_ok <= !back_frame_crc_ok;
        back_frame_gpio <= ~back_frame_gpio;
        back_frame_irq_n <= !back_frame_irq_n;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/test_link_sideband_gpio_interrupt.sv */
// Bench for the sideband block: pin modes, link pins, interrupt, power-down.
// Assumes the deserializer model is compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_link_sideband_gpio_interrupt;
  import lsg_pkg::*;
  logic clk, reset_n, power_down_n, link_detect, loc_req, loc_we, loc_rvalid, rem_req, rem_we;
  logic rem_ready, rem_rvalid, fwd_frame_strobe, irq_out_n, remote_irq_mirror, audio_surround_en;
  logic back_frame_valid, back_frame_crc_ok, back_frame_irq_n, irq_tx_n, crc_bad;
  lsg_byte_type loc_addr, loc_wdata, loc_rdata, rem_addr, rem_wdata, rem_rdata, rd;
  logic [3:0] back_frame_gpio, gpio_tx, fwd_frame_gpio, i2s_in_enable;
  logic [7:0] gpio_in, gpio_out, gpio_oe_n;
  int failures = 0;
  int checks_done = 0;
  localparam logic [7:0] maddr [8] = '{8'h0D, 8'h0E, 8'h0E, 8'h0F, 8'h10, 8'h10, 8'h11, 8'h11};
  localparam logic [7:0] laddr [8] = '{8'h1C, 8'h1C, 8'h1C, 8'h1C, 8'h1C, 8'h1C, 8'h1C, 8'h1D};
  localparam int msh [8] = '{0, 0, 4, 0, 0, 4, 0, 4};
  localparam int lbit [8] = '{0, 1, 2, 3, 5, 6, 7, 0};
  localparam logic [7:0] daddr [6] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'hC6};

  lsg_top dut (.clk, .reset_n, .power_down_n, .link_detect, .loc_req, .loc_we, .loc_addr, .loc_wdata,
    .loc_rdata, .loc_rvalid, .rem_req, .rem_we, .rem_addr, .rem_wdata, .rem_ready, .rem_rdata,
    .rem_rvalid, .back_frame_valid, .back_frame_crc_ok, .back_frame_gpio, .back_frame_irq_n,
    .fwd_frame_strobe, .fwd_frame_gpio, .gpio_in, .gpio_out, .gpio_oe_n, .i2s_in_enable,
    .audio_surround_en, .irq_out_n, .remote_irq_mirror);
  lsg_deser_model far_end (.clk, .reset_n, .gpio_tx, .irq_tx_n, .crc_bad, .back_frame_valid,
    .back_frame_crc_ok, .back_frame_gpio, .back_frame_irq_n);

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short
  initial begin
    #100us;
    failures++;
    stop_test();
  end

  // Step n edges, then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One register access on the local or remote port; read data lands in rd
  task automatic acc(input bit rem, input bit we, input lsg_byte_type a, input lsg_byte_type d);
    int n;
    n = 0;
    cyc(1);
    if (rem) begin
      {rem_req, rem_we, rem_addr, rem_wdata} = {1'b1, we, a, d};
    end else begin
      {loc_req, loc_we, loc_addr, loc_wdata} = {1'b1, we, a, d};
    end
    do @(posedge clk); while (rem && rem_ready !== 1'b1);
    #1;
    rem_req = 1'b0;
    loc_req = 1'b0;
    while (!we && (rem ? rem_rvalid : loc_rvalid) !== 1'b1 && n < 4) begin
      cyc(1);
      n++;
    end
    rd = rem ? rem_rdata : loc_rdata;
    if (n == 4) begin
      failures++;
      $display("mismatch rvalid expected 1 seen 0");
    end
  endtask

  // Byte comparison
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Single-bit comparison
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask

  // Read a register and compare under a mask
  task automatic rchk(input bit rem, input lsg_byte_type a, input lsg_byte_type e, input lsg_byte_type m);
    acc(rem, 1'b0, a, 8'h00);
    chk($sformatf("reg_%h", a), e, rd & m);
  endtask

  // Control registers at their defaults, unmapped reads zero
  task automatic test_defaults;
    int k;
    for (k = 0; k < 6; k++) rchk(0, daddr[k], 8'h00, 8'hFF);
    rchk(0, 8'h1A, 8'h01, 8'hFF);
    rchk(0, 8'h40, 8'h00, 8'hFF);
    chk("i2s_en", 8'h0F, {4'h0, i2s_in_enable});
    $display("test defaults done");
  endtask

  // Every pin through low, high and input modes
  task automatic test_modes;
    int k;
    for (k = 0; k < 8; k++) begin
      acc(0, 1, maddr[k], 8'h01 << msh[k]);
      cyc(2);
      chk("drive_l", 8'h00, {6'h00, gpio_oe_n[k], gpio_out[k]});
      if (k > 3) chkb("i2s_en", 1'b0, i2s_in_enable[k - 4]);
      acc(0, 1, maddr[k], 8'h09 << msh[k]);
      cyc(2);
      chk("drive_h", 8'h01, {6'h00, gpio_oe_n[k], gpio_out[k]});
      acc(0, 1, maddr[k], 8'h03 << msh[k]);
      gpio_in = 8'h01 << k;
      cyc(4);
      chkb("in_oe_n", 1'b1, gpio_oe_n[k]);
      rchk(0, laddr[k], 8'h01 << lbit[k], 8'h01 << lbit[k]);
      gpio_in = 8'h00;
      cyc(4);
      rchk(0, laddr[k], 8'h00, 8'h01 << lbit[k]);
      acc(0, 1, maddr[k], 8'h00);
    end
    $display("test modes done");
  endtask

  // Forward sampling and back-frame drive, bad frames ignored
  task automatic test_link_pins;
    acc(0, 1, 8'h0D, 8'h03);
    acc(0, 1, 8'h0E, 8'h55);
    acc(0, 1, 8'h0F, 8'h03);
    gpio_in = 8'h09;
    gpio_tx = 4'h6;
    cyc(4);
    fwd_frame_strobe = 1'b1;
    cyc(1);
    fwd_frame_strobe = 1'b0;
    cyc(1);
    chk("fwd", 8'h09, {4'h0, fwd_frame_gpio & 4'h9});
    cyc(12);
    chk("back", 8'h06, {4'h0, gpio_out[3:0] & 4'h6});
    chk("back_oe", 8'h00, {4'h0, gpio_oe_n[3:0] & 4'h6});
    crc_bad = 1'b1;
    gpio_tx = 4'h0;
    cyc(20);
    chk("back", 8'h06, {4'h0, gpio_out[3:0] & 4'h6});
    crc_bad = 1'b0;
    cyc(12);
    chk("back", 8'h00, {4'h0, gpio_out[3:0] & 4'h6});
    gpio_in = 8'h00;
    cyc(4);
    fwd_frame_strobe = 1'b1;
    cyc(1);
    fwd_frame_strobe = 1'b0;
    cyc(1);
    chk("fwd", 8'h00, {4'h0, fwd_frame_gpio & 4'h9});
    acc(0, 1, 8'h0D, 8'h00);
    acc(0, 1, 8'h0E, 8'h00);
    acc(0, 1, 8'h0F, 8'h00);
    $display("test link pins done");
  endtask

  // Remote interrupt raise, clear, re-arm and masking
  task automatic test_irq;
    acc(0, 1, 8'hC6, 8'h21);
    irq_tx_n = 1'b0;
    cyc(12);
    chkb("irq_out_n", 1'b0, irq_out_n);
    chkb("mirror", 1'b0, remote_irq_mirror);
    rchk(0, 8'hC7, 8'h21, 8'h23);
    cyc(1);
    chkb("irq_out_n", 1'b1, irq_out_n);
    cyc(16);
    chkb("irq_out_n", 1'b1, irq_out_n);
    chkb("mirror", 1'b0, remote_irq_mirror);
    irq_tx_n = 1'b1;
    cyc(12);
    chkb("mirror", 1'b1, remote_irq_mirror);
    irq_tx_n = 1'b0;
    cyc(12);
    chkb("irq_out_n", 1'b0, irq_out_n);
    rchk(1, 8'hC7, 8'h21, 8'h23);
    chkb("irq_out_n", 1'b1, irq_out_n);
    // Host clears the downstream source after reading status
    irq_tx_n = 1'b1;
    acc(0, 1, 8'hC6, 8'h01);
    cyc(12);
    irq_tx_n = 1'b0;
    cyc(12);
    chkb("irq_out_n", 1'b1, irq_out_n);
    irq_tx_n = 1'b1;
    acc(0, 1, 8'hC6, 8'h00);
    $display("test irq done");
  endtask

  // Cable fault seen as a cleared link bit, mirror forced high
  task automatic test_fault;
    acc(0, 1, 8'hC6, 8'h03);
    irq_tx_n = 1'b0;
    link_detect = 1'b0;
    cyc(4);
    chkb("irq_out_n", 1'b0, irq_out_n);
    rchk(0, 8'h0C, 8'h00, 8'h01);
    chkb("mirror", 1'b1, remote_irq_mirror);
    rchk(0, 8'hC7, 8'h03, 8'h23);
    chkb("irq_out_n", 1'b1, irq_out_n);
    link_detect = 1'b1;
    irq_tx_n = 1'b1;
    cyc(12);
    rchk(0, 8'h0C, 8'h01, 8'h01);
    acc(0, 1, 8'hC6, 8'h00);
    $display("test fault done");
  endtask

  // Local pins set and read back through the control channel
  task automatic test_remote;
    acc(1, 1, 8'h10, 8'h19);
    cyc(2);
    chk("loc_pins", 8'h01, {4'h0, gpio_oe_n[5:4], gpio_out[5:4]});
    rchk(1, 8'h10, 8'h19, 8'hFF);
    rchk(0, 8'h10, 8'h19, 8'hFF);
    acc(1, 1, 8'h10, 8'h00);
    $display("test remote done");
  endtask

  // Power-down returns every control register to default
  task automatic test_power;
    acc(0, 1, 8'h1A, 8'h00);
    acc(0, 1, 8'h0D, 8'h09);
    acc(0, 1, 8'hC6, 8'h21);
    cyc(2);
    chkb("surround", 1'b0, audio_surround_en);
    // Hold kept short: the block itself does not time it
    power_down_n = 1'b0;
    cyc(20);
    power_down_n = 1'b1;
    cyc(4);
    chkb("oe_n0", 1'b1, gpio_oe_n[0]);
    chkb("surround", 1'b1, audio_surround_en);
    test_defaults();
    $display("test power done");
  endtask

  // Print the counts and the verdict, then end the run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {reset_n, loc_req, loc_we, rem_req, rem_we, fwd_frame_strobe, crc_bad} = 7'h00;
    {power_down_n, link_detect, irq_tx_n} = 3'h7;
    {loc_addr, loc_wdata, rem_addr, rem_wdata, gpio_in} = 40'h0;
    gpio_tx = 4'h0;
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    cyc(3);
    test_defaults();
    test_modes();
    test_link_pins();
    test_irq();
    test_fault();
    test_remote();
    test_power();
    stop_test();
  end
endmodule
`default_nettype wire
